/* hbp_pkg.sv */
// package: constants and types for the host bus port
package hbp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int NUM_IRQ = 8;
    localparam int CM_DEPTH = 128;
    localparam int CM_AW = 7;
    // reset hold time in pcm clock cycles
    localparam int RESET_HOLD_CYC = 4;
    // demultiplexed map, bank 0 (operation)
    localparam logic [3:0] OFS_CM_ADDR = 4'h0;
    localparam logic [3:0] OFS_CM_DATA = 4'h1;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
    localparam logic [3:0] OFS_IRQ_SUPP = 4'h3;
    localparam logic [3:0] OFS_OP_MODE = 4'h4;
    localparam logic [3:0] OFS_CM_CTRL = 4'h5;
    // demultiplexed map, bank 1 (initialization)
    localparam logic [3:0] OFS_INIT0 = 4'h0;
    localparam logic [3:0] OFS_INIT1 = 4'h1;
    // multiplexed map: even byte addresses
    localparam logic [7:0] MUX_CM_ADDR = 8'h00;
    localparam logic [7:0] MUX_CM_DATA = 8'h02;
    localparam logic [7:0] MUX_IRQ_STAT = 8'h04;
    localparam logic [7:0] MUX_IRQ_SUPP = 8'h06;
    localparam logic [7:0] MUX_OP_MODE = 8'h08;
    localparam logic [7:0] MUX_CM_CTRL = 8'h0a;
    localparam logic [7:0] MUX_INIT0 = 8'h10;
    localparam logic [7:0] MUX_INIT1 = 8'h12;
    // field positions and reset values
    localparam int BANK_SEL_POS = 0;
    localparam int CM_RESET_MODE_POS = 1;
    localparam logic [7:0] OP_MODE_RST = 8'h02;
    localparam logic [7:0] IRQ_SUPP_RST = 8'h00;
    localparam logic [7:0] CM_RESET_CMD = 8'h01;
    typedef enum logic [1:0] {BUS_DS_RW, BUS_RD_WR, BUS_MUX} bus_type_t;
    typedef enum logic [3:0] {
        REG_NONE, REG_CM_ADDR, REG_CM_DATA, REG_IRQ_STAT, REG_IRQ_SUPP,
        REG_OP_MODE, REG_CM_CTRL, REG_INIT0, REG_INIT1
    } reg_sel_t;
endpackage : hbp_pkg

/* hbp_strobe_sync.sv */
// module: two-flop synchroniser with edge outputs for a group of pins
`timescale 1ns/100ps
`default_nettype none
module hbp_strobe_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // two stages, then one for edge detection; free running so the
    // stages already hold the pin levels when reset lifts
    always_ff @(posedge clk_i) begin
        meta_ff <= pin_i;
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
    end

    // edges masked in reset, idle-high pins give no false edge on release
    assign level_o = sync_ff;
    assign rise_o = rst_i ? {W{1'b0}} : (sync_ff & ~prev_ff);
    assign fall_o = rst_i ? {W{1'b0}} : (~sync_ff & prev_ff);
endmodule : hbp_strobe_sync
`default_nettype wire

/* host_bus_port_with_irq.sv */
// module: eight-bit parallel host port with bank select, interrupt and control memory
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_with_irq (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic CS_N_I,
    input wire logic ALE_I,
    input wire logic CTRL_A_I,
    input wire logic CTRL_B_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic DATA_OE_O,
    output logic INT_N_O,
    input wire logic [7:0] IRQ_EVENT_I,
    output logic [7:0] INIT0_O,
    output logic [7:0] INIT1_O,
    output logic CM_RESET_MODE_O,
    output logic [1:0] BUS_TYPE_O,
    input wire logic [6:0] CM_RD_ADDR_I,
    output logic [7:0] CM_RD_DATA_O
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pins: 0 chip select, 1 latch, 2 ctrl a, 3 ctrl b
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [11:0] bus_meta_ff;
    logic [11:0] bus_sync_ff;

    hbp_strobe_sync #(.W(4)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .pin_i({CTRL_B_I, CTRL_A_I, ALE_I, CS_N_I}),
        .level_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // address and data pins, two stages
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            bus_meta_ff <= 12'h000;
            bus_sync_ff <= 12'h000;
        end else begin
            bus_meta_ff <= {ADDR_I, DATA_I};
            bus_sync_ff <= bus_meta_ff;
        end
    end

    wire cs_act = ~pin_lvl[0];
    wire [7:0] data_s = bus_sync_ff[7:0];
    wire [3:0] addr_s = bus_sync_ff[11:8];

    // ------------------------------------------------------------
    // bus type selection
    // ------------------------------------------------------------
    hbp_pkg::bus_type_t bus_type_ff;
    logic strap_ff;
    logic in_reset_ff;

    // strap sampled while reset is held, mux entry on any latch edge
    always_ff @(posedge CORE_CLK_I) begin
        in_reset_ff <= RST_I;
        if (RST_I) begin
            strap_ff <= pin_lvl[1];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            bus_type_ff <= hbp_pkg::BUS_RD_WR;
        end else if (pin_rise[1] | pin_fall[1]) begin
            bus_type_ff <= hbp_pkg::BUS_MUX;
        end else if (in_reset_ff) begin
            bus_type_ff <= strap_ff ? hbp_pkg::BUS_DS_RW : hbp_pkg::BUS_RD_WR;
        end
    end

    wire is_mux = (bus_type_ff == hbp_pkg::BUS_MUX);
    wire is_dsrw = (bus_type_ff == hbp_pkg::BUS_DS_RW);

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    // ds/rw: ctrl a is data strobe_n, ctrl b is read-not-write
    // rd/wr: ctrl a is read_n, ctrl b is write_n
    wire rd_level = cs_act & (is_dsrw ? (~pin_lvl[2] & pin_lvl[3]) : ~pin_lvl[2]);
    wire wr_level = cs_act & (is_dsrw ? (~pin_lvl[2] & ~pin_lvl[3]) : ~pin_lvl[3]);

    // ------------------------------------------------------------
    // multiplexed address latch
    // ------------------------------------------------------------
    logic [7:0] mux_addr_ff;

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            mux_addr_ff <= 8'h00;
        end else if (pin_fall[1]) begin
            mux_addr_ff <= data_s;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0] op_mode_ff;
    wire bank_sel = op_mode_ff[hbp_pkg::BANK_SEL_POS];

    function automatic hbp_pkg::reg_sel_t decode_mux(input logic [7:0] a);
        hbp_pkg::reg_sel_t r;
        r = hbp_pkg::REG_NONE;
        unique case (a)
            hbp_pkg::MUX_CM_ADDR: r = hbp_pkg::REG_CM_ADDR;
            hbp_pkg::MUX_CM_DATA: r = hbp_pkg::REG_CM_DATA;
            hbp_pkg::MUX_IRQ_STAT: r = hbp_pkg::REG_IRQ_STAT;
            hbp_pkg::MUX_IRQ_SUPP: r = hbp_pkg::REG_IRQ_SUPP;
            hbp_pkg::MUX_OP_MODE: r = hbp_pkg::REG_OP_MODE;
            hbp_pkg::MUX_CM_CTRL: r = hbp_pkg::REG_CM_CTRL;
            hbp_pkg::MUX_INIT0: r = hbp_pkg::REG_INIT0;
            hbp_pkg::MUX_INIT1: r = hbp_pkg::REG_INIT1;
            default: r = hbp_pkg::REG_NONE; // odd addresses unmapped
        endcase
        return r;
    endfunction : decode_mux

    function automatic hbp_pkg::reg_sel_t decode_demux(input logic [3:0] a, input logic bank);
        hbp_pkg::reg_sel_t r;
        r = hbp_pkg::REG_NONE;
        if (a == hbp_pkg::OFS_OP_MODE) begin
            r = hbp_pkg::REG_OP_MODE;
        end else if (bank) begin
            if (a == hbp_pkg::OFS_INIT0) r = hbp_pkg::REG_INIT0;
            else if (a == hbp_pkg::OFS_INIT1) r = hbp_pkg::REG_INIT1;
        end else begin
            unique case (a)
                hbp_pkg::OFS_CM_ADDR: r = hbp_pkg::REG_CM_ADDR;
                hbp_pkg::OFS_CM_DATA: r = hbp_pkg::REG_CM_DATA;
                hbp_pkg::OFS_IRQ_STAT: r = hbp_pkg::REG_IRQ_STAT;
                hbp_pkg::OFS_IRQ_SUPP: r = hbp_pkg::REG_IRQ_SUPP;
                hbp_pkg::OFS_CM_CTRL: r = hbp_pkg::REG_CM_CTRL;
                default: r = hbp_pkg::REG_NONE;
            endcase
        end
        return r;
    endfunction : decode_demux

    // multiplexed map differs from demultiplexed map
    wire hbp_pkg::reg_sel_t sel = is_mux ? decode_mux(mux_addr_ff) : decode_demux(addr_s, bank_sel);

    logic rd_busy_ff;
    logic wr_level_ff;
    logic [7:0] wr_data_ff;
    hbp_pkg::reg_sel_t wr_sel_ff;

    // data and target held from the strobe phase, since chip select,
    // strobe and data may all be released at the same edge
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            wr_level_ff <= 1'b0;
            wr_data_ff <= 8'h00;
            wr_sel_ff <= hbp_pkg::REG_NONE;
        end else begin
            wr_level_ff <= wr_level;
            if (wr_level) begin
                wr_data_ff <= data_s;
                wr_sel_ff <= sel;
            end
        end
    end

    // write completes when the write level ends
    wire wr_done = wr_level_ff & ~wr_level;
    // access types: status read only, control write read, rest read/write
    wire wr_ok = (wr_sel_ff != hbp_pkg::REG_NONE) && (wr_sel_ff != hbp_pkg::REG_IRQ_STAT);
    wire wr_stb = wr_done & wr_ok;
    wire rd_start = rd_level & ~rd_busy_ff;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] irq_supp_ff;
    logic [7:0] irq_stat_ff;
    logic [7:0] init0_ff;
    logic [7:0] init1_ff;
    logic [6:0] cm_addr_ff;
    logic cm_reset_mode_ff;

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            op_mode_ff <= hbp_pkg::OP_MODE_RST;
            irq_supp_ff <= hbp_pkg::IRQ_SUPP_RST;
            init0_ff <= 8'h00;
            init1_ff <= 8'h00;
            cm_addr_ff <= 7'h00;
            cm_reset_mode_ff <= 1'b1;
        end else if (wr_stb) begin
            unique case (wr_sel_ff)
                hbp_pkg::REG_OP_MODE: begin
                    // bit 1 ignores the written value; only the control memory reset command clears reset mode, memory is not cleared
                    op_mode_ff <= {wr_data_ff[7:2], cm_reset_mode_ff, wr_data_ff[0]};
                end
                hbp_pkg::REG_IRQ_SUPP: irq_supp_ff <= wr_data_ff;
                hbp_pkg::REG_INIT0: init0_ff <= wr_data_ff;
                hbp_pkg::REG_INIT1: init1_ff <= wr_data_ff;
                hbp_pkg::REG_CM_ADDR: cm_addr_ff <= wr_data_ff[6:0];
                hbp_pkg::REG_CM_CTRL: begin
                    if (wr_data_ff == hbp_pkg::CM_RESET_CMD) cm_reset_mode_ff <= 1'b0;
                end
                hbp_pkg::REG_CM_DATA: cm_addr_ff <= cm_addr_ff + 7'h01; // data write advances
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control memory, host port and switching read port
    // ------------------------------------------------------------
    logic [7:0] cm_mem [0:hbp_pkg::CM_DEPTH-1];
    logic [7:0] cm_rd_ff;

    // not cleared by reset, contents survive hardware reset
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_stb && wr_sel_ff == hbp_pkg::REG_CM_DATA) begin
            cm_mem[cm_addr_ff] <= wr_data_ff;
        end
        cm_rd_ff <= cm_mem[CM_RD_ADDR_I];
    end

    // ------------------------------------------------------------
    // interrupt status and line
    // ------------------------------------------------------------
    wire [7:0] ev_in = IRQ_EVENT_I & ~irq_supp_ff;
    wire stat_rd_clr = rd_start && (sel == hbp_pkg::REG_IRQ_STAT);
    logic supp_wr_ff;

    // set beats the read clear
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            irq_stat_ff <= 8'h00;
        end else begin
            irq_stat_ff <= ((stat_rd_clr ? 8'h00 : irq_stat_ff) | ev_in) & ~irq_supp_ff;
        end
    end

    // suppress write window: from strobe active until release
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            supp_wr_ff <= 1'b0;
        end else begin
            supp_wr_ff <= wr_level && (sel == hbp_pkg::REG_IRQ_SUPP);
        end
    end

    // level line, low while anything pending unless suppress write
    wire int_act = (|irq_stat_ff) & ~supp_wr_ff;

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    logic [7:0] rd_data_ff;
    logic oe_ff;
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (sel)
            hbp_pkg::REG_CM_ADDR: rd_mux = {1'b0, cm_addr_ff};
            hbp_pkg::REG_CM_DATA: rd_mux = cm_mem[cm_addr_ff];
            hbp_pkg::REG_IRQ_STAT: rd_mux = irq_stat_ff;
            hbp_pkg::REG_IRQ_SUPP: rd_mux = irq_supp_ff;
            hbp_pkg::REG_OP_MODE: rd_mux = {op_mode_ff[7:2], cm_reset_mode_ff, op_mode_ff[0]};
            hbp_pkg::REG_CM_CTRL: rd_mux = {7'h00, cm_reset_mode_ff};
            hbp_pkg::REG_INIT0: rd_mux = init0_ff;
            hbp_pkg::REG_INIT1: rd_mux = init1_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    // data captured at read start, held for the strobe
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rd_data_ff <= 8'h00;
            rd_busy_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            rd_busy_ff <= rd_level;
            oe_ff <= rd_level;
            if (rd_start) rd_data_ff <= rd_mux;
        end
    end

    assign DATA_O = rd_data_ff;
    assign DATA_OE_O = oe_ff & rd_level;
    assign INT_N_O = ~int_act;
    assign INIT0_O = init0_ff;
    assign INIT1_O = init1_ff;
    assign CM_RESET_MODE_O = cm_reset_mode_ff;
    assign BUS_TYPE_O = bus_type_ff;
    assign CM_RD_DATA_O = cm_rd_ff;
endmodule : host_bus_port_with_irq
`default_nettype wire

/* host_bus_port_with_irq_properties.sv */
// checker: pin-level timing relations of the host bus port
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_with_irq_properties (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic CS_N_I,
    input wire logic ALE_I,
    input wire logic CTRL_A_I,
    input wire logic CTRL_B_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] DATA_I,
    input wire logic [7:0] DATA_O,
    input wire logic DATA_OE_O,
    input wire logic INT_N_O,
    input wire logic [7:0] IRQ_EVENT_I,
    input wire logic [7:0] INIT0_O,
    input wire logic [7:0] INIT1_O,
    input wire logic CM_RESET_MODE_O,
    input wire logic [1:0] BUS_TYPE_O,
    input wire logic [6:0] CM_RD_ADDR_I,
    input wire logic [7:0] CM_RD_DATA_O
);
    // ------------------------------------------------------------
    // helper decode and idle counter
    // ------------------------------------------------------------
    logic [3:0] idle_ff;
    wire logic rd_act = !CS_N_I && !CTRL_A_I && (BUS_TYPE_O != 2'h0 || CTRL_B_I);
    wire logic supp_wr = !CS_N_I && !CTRL_B_I && BUS_TYPE_O == 2'h1 && ADDR_I == 4'h3;
    // cycles since chip select was last low
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || !CS_N_I) begin
            idle_ff <= 4'h0;
        end else if (idle_ff != 4'hf) begin
            idle_ff <= idle_ff + 4'h1;
        end
    end
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    sequence s_supp_write;
        supp_wr [*4];
    endsequence
    sequence s_read_start;
        !rd_act ##1 rd_act;
    endsequence
    a_reset_values: assert property (
        disable iff (1'b0) RST_I |=> INT_N_O && !DATA_OE_O && CM_RESET_MODE_O)
        else $error("outputs not at reset values");
    a_strap_type: assert property (
        $fell(RST_I) |-> ##[1:3] BUS_TYPE_O == {1'b0, !ALE_I})
        else $error("bus type does not follow strap");
    a_ale_edge_mux: assert property ($changed(ALE_I) |-> ##[1:5] BUS_TYPE_O == 2'h2)
        else $error("latch edge did not select mux");
    a_mux_sticky: assert property (BUS_TYPE_O == 2'h2 |=> BUS_TYPE_O == 2'h2)
        else $error("left mux without reset");
    a_read_answer: assert property (s_read_start |-> ##[1:5] DATA_OE_O)
        else $error("read not answered");
    a_oe_cause: assert property ($rose(DATA_OE_O) |-> $past(rd_act, 2))
        else $error("bus driven without read");
    a_oe_release: assert property ($fell(rd_act) |-> ##[1:4] !DATA_OE_O)
        else $error("bus held after read");
    a_supp_int_off: assert property (s_supp_write |-> INT_N_O)
        else $error("interrupt active in suppress write");
    a_int_level: assert property (!INT_N_O && idle_ff > 4'h6 |=> !INT_N_O)
        else $error("interrupt dropped without service");
    a_cm_mode_sticky: assert property (!CM_RESET_MODE_O |=> !CM_RESET_MODE_O)
        else $error("control memory reset mode reentered");
    a_init_cause: assert property ($changed(INIT0_O) |-> idle_ff < 4'h8)
        else $error("init register changed without access");
endmodule : host_bus_port_with_irq_properties
bind host_bus_port_with_irq host_bus_port_with_irq_properties i_host_bus_port_with_irq_properties (
    .CORE_CLK_I, .RST_I, .CS_N_I, .ALE_I, .CTRL_A_I, .CTRL_B_I, .ADDR_I, .DATA_I, .DATA_O,
    .DATA_OE_O, .INT_N_O, .IRQ_EVENT_I, .INIT0_O, .INIT1_O, .CM_RESET_MODE_O, .BUS_TYPE_O,
    .CM_RD_ADDR_I, .CM_RD_DATA_O);
`default_nettype wire

/* hbp_host_model.sv */
// host model: cycles of the three bus types on the parallel port
`timescale 1ns/100ps
`default_nettype none
module hbp_host_model (
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_oe_i,
    output logic cs_n_o,
    output logic ale_o,
    output logic ctrl_a_o,
    output logic ctrl_b_o,
    output logic [3:0] addr_o,
    output logic [7:0] data_o
);
    // ------------------------------------------------------------
    // bus pins and cycle tasks
    // ------------------------------------------------------------
    logic drv;
    logic [7:0] dq;
    logic [7:0] last_q;
    initial begin
        {cs_n_o, ctrl_a_o, ctrl_b_o} = 3'h7;
        {ale_o, drv, addr_o, dq, last_q} = '0;
    end
    // released and undriven bus shows a toggling pattern, never the last value
    assign data_o = drv ? dq : ((rd_oe_i === 1'b1) ? rd_data_i : ~last_q);
    always @(posedge clk_i) last_q <= data_o;
    task automatic strap(input logic v);
        ale_o <= v;
    endtask : strap
    task automatic toggle_ale;
        ale_o <= !ale_o;
        repeat (8) @(posedge clk_i);
    endtask : toggle_ale
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_i);
        if (mode_i == 2'h2) begin
            ale_o <= 1'b1;
            drv <= 1'b1;
            dq <= {a[7:1], 1'b0};
            repeat (3) @(posedge clk_i);
            ale_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        cs_n_o <= 1'b0;
        addr_o <= a[3:0];
        dq <= d;
        drv <= wr;
        ctrl_a_o <= (mode_i == 2'h0) ? 1'b0 : wr;
        ctrl_b_o <= !wr;
        repeat (6) @(posedge clk_i);
        q = rd_data_i;
        {cs_n_o, ctrl_a_o, ctrl_b_o} <= 3'h7;
        drv <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : acc
endmodule : hbp_host_model
`default_nettype wire

/* host_bus_port_with_irq_bench.sv */
// testbench: host port scenarios driven through the host model
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_with_irq_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [6:0] cm_a = 7'h00;
    logic [1:0] mode = 2'h1;
    logic cs_n, ale, ctl_a, ctl_b, oe, int_n, cm_rst;
    logic [3:0] addr;
    logic [7:0] bus, rdat, init0, init1, cm_d, q;
    logic [1:0] btype;
    int fails = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    hbp_host_model i_hbp_host_model (.clk_i(clk), .mode_i(mode), .rd_data_i(rdat),
        .rd_oe_i(oe), .cs_n_o(cs_n), .ale_o(ale), .ctrl_a_o(ctl_a), .ctrl_b_o(ctl_b),
        .addr_o(addr), .data_o(bus));
    host_bus_port_with_irq i_host_bus_port_with_irq (.CORE_CLK_I(clk), .RST_I(rst),
        .CS_N_I(cs_n), .ALE_I(ale), .CTRL_A_I(ctl_a), .CTRL_B_I(ctl_b), .ADDR_I(addr),
        .DATA_I(bus), .DATA_O(rdat), .DATA_OE_O(oe), .INT_N_O(int_n), .IRQ_EVENT_I(ev),
        .INIT0_O(init0), .INIT1_O(init1), .CM_RESET_MODE_O(cm_rst), .BUS_TYPE_O(btype),
        .CM_RD_ADDR_I(cm_a), .CM_RD_DATA_O(cm_d));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_hbp_host_model.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_hbp_host_model.acc(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic do_reset(input logic s, input logic [1:0] bt);
        @(posedge clk);
        rst <= 1'b1;
        i_hbp_host_model.strap(s);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        mode <= bt;
        repeat (6) @(posedge clk);
        chk({6'h00, btype}, {6'h00, bt});
        chk({7'h00, cm_rst}, 8'h01);
        chk({7'h00, int_n}, 8'h01);
        $display("reset test done");
    endtask : do_reset
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_irq;
        rd(8'h04);
        chk(q, hbp_pkg::OP_MODE_RST);
        pulse(8'h08);
        chk({7'h00, int_n}, 8'h00);
        pulse(8'h02);
        rd(8'h02);
        chk(q, 8'h0a);
        chk({7'h00, int_n}, 8'h01);
        wr(8'h03, 8'h08);
        pulse(8'h0c);
        chk({7'h00, int_n}, 8'h00);
        rd(8'h02);
        chk(q, 8'h04);
        pulse(8'h08);
        chk({7'h00, int_n}, 8'h01);
        wr(8'h02, 8'hff);
        rd(8'h02);
        chk(q, 8'h00);
        rd(8'h03);
        chk(q, 8'h08);
        rd(8'h0f);
        chk(q, 8'h00);
        pulse(8'h01);
        wr(8'h03, 8'h00);
        chk({7'h00, int_n}, 8'h00);
        rd(8'h02);
        chk(q, 8'h01);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_bank;
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h5a);
        chk(init0, 8'h5a);
        wr(8'h01, 8'ha5);
        chk(init1, 8'ha5);
        rd(8'h04);
        chk(q, 8'h03);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h11);
        chk(init0, 8'h5a);
        rd(8'h04);
        chk(q, 8'h02);
        $display("bank test done");
    endtask : t_bank
    task automatic t_cm;
        wr(8'h05, hbp_pkg::CM_RESET_CMD);
        chk({7'h00, cm_rst}, 8'h00);
        wr(8'h00, 8'h05);
        wr(8'h01, 8'h77);
        wr(8'h01, 8'h66);
        cm_a <= 7'h05;
        repeat (2) @(posedge clk);
        chk(cm_d, 8'h77);
        cm_a <= 7'h06;
        repeat (2) @(posedge clk);
        chk(cm_d, 8'h66);
        $display("memory test done");
    endtask : t_cm
    task automatic t_dsrw;
        cm_a <= 7'h05;
        repeat (2) @(posedge clk);
        chk(cm_d, 8'h77);
        wr(8'h04, 8'h01);
        rd(8'h04);
        chk(q, 8'h03);
        wr(8'h00, 8'hc3);
        chk(init0, 8'hc3);
        $display("strobe type test done");
    endtask : t_dsrw
    task automatic t_mux;
        i_hbp_host_model.toggle_ale;
        chk({6'h00, btype}, 8'h02);
        mode <= 2'h2;
        wr(8'h10, 8'h3c);
        chk(init0, 8'h3c);
        wr(8'h12, 8'h96);
        chk(init1, 8'h96);
        rd(8'h08);
        chk(q, 8'h03);
        chk({6'h00, btype}, 8'h02);
        $display("mux test done");
    endtask : t_mux
    initial begin
        do_reset(1'b0, 2'h1);
        t_irq;
        t_bank;
        t_cm;
        do_reset(1'b1, 2'h0);
        t_dsrw;
        t_mux;
        do_reset(1'b0, 2'h1);
        test_done;
    end
    // watchdog against a hang
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule : host_bus_port_with_irq_bench
`default_nettype wire
